// *** rtl/timer_watchdog_unit.sv ***
// Periodic timer and keyed watchdog with a simple register port
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module timer_watchdog_unit (
  input  wire logic                mclk,       // System clock, 250 MHz
  input  wire logic                reset,      // Synchronous reset, active high
  input  wire logic                clk_en,     // Freezes all state while low
  input  wire logic                slow_clk,   // Slow clock pin, asynchronous
  input  wire logic                freeze_in,  // Debug freeze pin, asynchronous
  input  twu_pkg::reg_req_type     bus_req,    // Register request
  output logic [15:0]              rdata,      // Read data, cycle after read strobe
  output logic                     timer_irq,  // Timer interrupt, one-cycle pulse
  output logic                     wd_reset    // Whole-device reset request, level
);
  import twu_pkg::*;

  typedef enum logic [2:0] {
    WD_IDLE = 3'b001,
    WD_RUN  = 3'b010,
    WD_ERR  = 3'b100
  } wd_state_type;

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  logic [2:0] slow_sy_q;
  logic [2:0] slow_sy_d;
  logic [2:0] frz_sy_q;
  logic [2:0] frz_sy_d;
  logic       slow_lvl_q;
  logic       slow_lvl_d;
  logic       frz_lvl_q;
  logic       frz_lvl_d;
  logic       slow_tick;

  always_comb
  begin
    slow_sy_d  = {slow_sy_q[1:0], slow_clk};
    frz_sy_d   = {frz_sy_q[1:0], freeze_in};
    slow_lvl_d = slow_lvl_q;
    frz_lvl_d  = frz_lvl_q;
    // A level counts only once the second and third stages agree
    if (slow_sy_q[1] == slow_sy_q[2])
      slow_lvl_d = slow_sy_q[2];
    if (frz_sy_q[1] == frz_sy_q[2])
      frz_lvl_d = frz_sy_q[2];
    slow_tick = slow_lvl_d & ~slow_lvl_q;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      slow_sy_q  <= 3'h0;
      frz_sy_q   <= 3'h0;
      slow_lvl_q <= 1'b0;
      frz_lvl_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      slow_sy_q  <= slow_sy_d;
      frz_sy_q   <= frz_sy_d;
      slow_lvl_q <= slow_lvl_d;
      frz_lvl_q  <= frz_lvl_d;
    end
  end

  // ******************************************************************
  // Registers, timer and watchdog
  // ******************************************************************
  logic [5:0]   cfg_q, cfg_d;
  logic [2:0]   presc_q, presc_d;
  logic [15:0]  reload_q, reload_d;
  logic [15:0]  tmr_q, tmr_d;
  logic [4:0]   div_q, div_d;
  logic         restart_q, restart_d;
  logic         term_q, term_d;
  logic         irq_en_q, irq_en_d;
  logic         frz_en_q, frz_en_d;
  logic         ltd_q, ltd_d;
  logic         irq_q, irq_d;
  logic [7:0]   wd_count_q, wd_count_d;
  logic [7:0]   wd_q, wd_d;
  logic         svc_q, svc_d;
  wd_state_type wd_st_q, wd_st_d;
  logic [15:0]  rdata_q, rdata_d;

  logic [5:0]   div_span;
  logic [4:0]   div_lim;
  logic         tin_tick;
  logic         frozen;
  logic         underflow;
  logic         wd_tick;
  logic         wr_cfg, wr_presc, wr_reload, wr_csr, wr_wd_count, wr_key;
  logic         key_ok, wd_err;

  always_comb
  begin
    cfg_d     = cfg_q;
    presc_d   = presc_q;
    reload_d  = reload_q;
    tmr_d     = tmr_q;
    div_d     = div_q;
    restart_d = restart_q;
    term_d    = term_q;
    irq_en_d  = irq_en_q;
    frz_en_d  = frz_en_q;
    ltd_d     = ltd_q;
    wd_count_d = wd_count_q;
    wd_d      = wd_q;
    svc_d     = svc_q;
    wd_st_d   = wd_st_q;
    rdata_d   = 16'h0000;
    wd_err    = 1'b0;

    // Lock bits gate writes; a locked register ignores writes until reset, though status bits in CSR still change
    wr_cfg    = bus_req.wr & (bus_req.addr == OFS_CFG) & ~cfg_q[CFG_LOCK_CFG];
    wr_presc  = bus_req.wr & (bus_req.addr == OFS_PRESC) & ~cfg_q[CFG_LOCK_PRESC];
    wr_reload = bus_req.wr & (bus_req.addr == OFS_RELOAD) & ~cfg_q[CFG_LOCK_TMR];
    wr_csr    = bus_req.wr & (bus_req.addr == OFS_CSR) & ~cfg_q[CFG_LOCK_TMR];
    wr_wd_count = bus_req.wr & (bus_req.addr == OFS_WD_COUNT) & ~cfg_q[CFG_LOCK_WD_COUNT];
    wr_key    = bus_req.wr & (bus_req.addr == OFS_KEY);
    key_ok    = bus_req.wdata[7:0] == SERVICE_KEY;

    // Prescaler: divide by 2**code, reserved codes give no input clock
    div_span = 6'h01 << presc_q;
    div_lim  = 5'(div_span - 6'h01);
    tin_tick = slow_tick & (presc_q <= DIV_CODE_MAX) & (div_q == div_lim);
    if (slow_tick)
      div_d = (div_q >= div_lim) ? 5'h00 : 5'(div_q + 5'h01);

    frozen    = frz_en_q & frz_lvl_q;
    underflow = tin_tick & ~restart_q & ~frozen & (tmr_q == 16'h0001);

    // Timer
    if (tin_tick)
    begin
      if (restart_q)
      begin
        tmr_d     = reload_q;
        restart_d = 1'b0;
      end
      else if (!frozen)
      begin
        if (tmr_q == 16'h0000)
          tmr_d = reload_q;
        else
          tmr_d = tmr_q - 16'h0001;
      end
    end
    irq_d = underflow & irq_en_q;

    // Flag is cleared by reading the status register, a new event wins
    term_d = underflow | (term_q & ~(bus_req.rd & (bus_req.addr == OFS_CSR) &
             ~cfg_q[CFG_LOCK_TMR]));

    // Register writes
    if (wr_cfg)
      cfg_d = bus_req.wdata[5:0] | (cfg_q & 6'h0f);
    if (wr_presc)
      presc_d = bus_req.wdata[2:0];
    if (wr_reload)
      reload_d = bus_req.wdata;
    if (wr_csr)
    begin
      if (bus_req.wdata[CSR_RESTART])
        restart_d = 1'b1;
      irq_en_d = bus_req.wdata[CSR_IRQ_EN];
      frz_en_d = bus_req.wdata[CSR_FREEZE_EN];
    end

    // Watchdog
    wd_tick = cfg_q[CFG_WD_CLK_SEL] ? tin_tick : underflow;
    if (wd_tick)
      svc_d = 1'b0;
    if (wd_st_q == WD_RUN && wd_tick)
    begin
      if (wd_q == 8'h00)
        wd_err = 1'b1;
      else
        wd_d = wd_q - 8'h01;
    end
    if (wr_wd_count)
    begin
      wd_count_d = bus_req.wdata[7:0];
      wd_d    = bus_req.wdata[7:0];
      if (wd_st_q == WD_IDLE)
        wd_st_d = WD_RUN;
    end
    if (wr_key && cfg_q[CFG_KEYED])
    begin
      if (!key_ok)
        wd_err = 1'b1;
      else if (svc_q)
        wd_err = 1'b1;
      else
      begin
        wd_d  = wd_count_q;
        svc_d = 1'b1;
        if (wd_st_q == WD_IDLE)
          wd_st_d = WD_RUN;
      end
    end
    // Transfer stays pending until the slow domain has taken it
    ltd_d = wr_wd_count | (wr_key & cfg_q[CFG_KEYED]) | (ltd_q & ~slow_tick);

    case (wd_st_q)
      WD_IDLE: wd_st_d = wd_st_d;
      WD_RUN:  if (wd_err) wd_st_d = WD_ERR;
      WD_ERR:  wd_st_d = WD_ERR;
      default: wd_st_d = WD_IDLE;
    endcase
    if (wd_st_q == WD_IDLE && wd_err)
      wd_st_d = WD_ERR;

    // Read side; locked and write-only registers read as zero
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        OFS_CFG:    rdata_d = cfg_q[CFG_LOCK_CFG] ? 16'h0000 : {10'h000, cfg_q};
        OFS_PRESC:  rdata_d = cfg_q[CFG_LOCK_PRESC] ? 16'h0000 : {13'h0000, presc_q};
        OFS_RELOAD: rdata_d = cfg_q[CFG_LOCK_TMR] ? 16'h0000 : reload_q;
        OFS_CSR:    rdata_d = cfg_q[CFG_LOCK_TMR] ? 16'h0000 :
                    {11'h000, frz_en_q, ltd_q, irq_en_q, term_q, restart_q};
        default:    rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cfg_q     <= CFG_RST;
      presc_q   <= PRESC_RST;
      reload_q  <= RELOAD_RST;
      tmr_q     <= RELOAD_RST;
      div_q     <= 5'h00;
      restart_q <= 1'b0;
      term_q    <= 1'b0;
      irq_en_q  <= 1'b0;
      frz_en_q  <= 1'b0;
      ltd_q     <= 1'b0;
      irq_q     <= 1'b0;
      wd_count_q <= WD_COUNT_RST;
      wd_q      <= WD_COUNT_RST;
      svc_q     <= 1'b0;
      wd_st_q   <= WD_IDLE;
      rdata_q   <= 16'h0000;
    end
    else if (clk_en)
    begin
      cfg_q     <= cfg_d;
      presc_q   <= presc_d;
      reload_q  <= reload_d;
      tmr_q     <= tmr_d;
      div_q     <= div_d;
      restart_q <= restart_d;
      term_q    <= term_d;
      irq_en_q  <= irq_en_d;
      frz_en_q  <= frz_en_d;
      ltd_q     <= ltd_d;
      irq_q     <= irq_d;
      wd_count_q <= wd_count_d;
      wd_q      <= wd_d;
      svc_q     <= svc_d;
      wd_st_q   <= wd_st_d;
      rdata_q   <= rdata_d;
    end
  end

  assign rdata     = rdata_q;
  assign timer_irq = irq_q;
  assign wd_reset  = wd_st_q == WD_ERR;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_RELOAD: assert property (clk_en && tin_tick && !restart_q && !frozen &&
    tmr_q == 16'h0000 |=> tmr_q == $past(reload_q))
    else $error("timer did not reload from preset");
  AST_RESTART: assert property (clk_en && tin_tick && restart_q && !wr_csr |=>
    !restart_q && tmr_q == $past(reload_q))
    else $error("restart not performed and cleared on input edge");
  AST_RST_HOLD: assert property (clk_en && restart_q && !tin_tick |=> restart_q)
    else $error("restart bit dropped before the input edge");
  AST_TERM: assert property (clk_en && underflow |=> term_q)
    else $error("terminal count not set at zero");
  AST_IRQ: assert property (clk_en |=> timer_irq == $past(underflow && irq_en_q))
    else $error("timer interrupt mismatch");
  AST_FREEZE: assert property (clk_en && frozen && !restart_q |=> $stable(tmr_q))
    else $error("timer moved while frozen");
  AST_BADKEY: assert property (clk_en && wr_key && cfg_q[CFG_KEYED] && !key_ok
    |=> wd_reset)
    else $error("wrong key did not raise watchdog error");
  AST_IGNORE: assert property (clk_en && wr_key && !cfg_q[CFG_KEYED] && !wd_tick
    |=> $stable(wd_q) && $stable(wd_st_q))
    else $error("key write acted while keyed servicing off");
  AST_LATE: assert property (clk_en && wd_st_q == WD_RUN && wd_tick &&
    wd_q == 8'h00 && !wr_wd_count && !wr_key |=> wd_reset)
    else $error("late service not flagged");
  AST_LOCK: assert property (cfg_q[CFG_LOCK_CFG] |=> cfg_q[CFG_LOCK_CFG] &&
    $stable(cfg_q))
    else $error("locked configuration changed");
  AST_LOCK_PRESC: assert property (cfg_q[CFG_LOCK_PRESC] |=> $stable(presc_q))
    else $error("locked prescale changed");
  AST_LOCK_TMR: assert property (cfg_q[CFG_LOCK_TMR] |=> $stable(reload_q) &&
    $stable(irq_en_q) && $stable(frz_en_q))
    else $error("locked timer registers changed");
  AST_LOCK_WDC: assert property (cfg_q[CFG_LOCK_WD_COUNT] |=> $stable(wd_count_q))
    else $error("locked watchdog count changed");

  // Reset itself is checked here, so this one is never disabled
  AST_CSR_RST: assert property (disable iff (1'b0) reset |=> !restart_q &&
    !term_q && !irq_en_q && !ltd_q && !frz_en_q)
    else $error("control and status bits not cleared by reset");
  AST_LTD_SET: assert property (clk_en &&
    (wr_wd_count || (wr_key && cfg_q[CFG_KEYED])) |=> ltd_q)
    else $error("last-touch bit not set by watchdog write");
  AST_LTD_CLR: assert property (clk_en && ltd_q && slow_tick &&
    !wr_wd_count && !wr_key |=> !ltd_q)
    else $error("last-touch bit stuck after slow edge");
  AST_START: assert property (clk_en && wd_st_q == WD_IDLE && wr_wd_count
    |=> wd_st_q == WD_RUN)
    else $error("count write did not start watchdog");
  AST_GOODKEY: assert property (clk_en && wr_key && cfg_q[CFG_KEYED] && key_ok &&
    !svc_q |=> wd_q == $past(wd_count_q))
    else $error("good key did not reload watchdog");
  AST_TWICE: assert property (clk_en && wr_key && cfg_q[CFG_KEYED] && key_ok &&
    svc_q |=> wd_reset)
    else $error("second key within one watchdog tick not flagged");
  AST_STICKY: assert property (wd_reset |=> wd_reset)
    else $error("watchdog reset request dropped");

  COV_UNDERFLOW_IRQ: cover property (timer_irq);
  COV_KEY_SERVICE: cover property (clk_en && wr_key && cfg_q[CFG_KEYED] && key_ok);
  COV_WD_ERROR: cover property (wd_st_q == WD_RUN ##1 wd_st_q == WD_ERR);
  COV_RESTART: cover property (clk_en && tin_tick && restart_q);
  COV_FROZEN: cover property (clk_en && frozen && tin_tick);

endmodule : timer_watchdog_unit

// *** shared/twu_pkg.sv ***
// Constants, field layout and bus carrier for the timer and watchdog unit
//
// Behaviour
// - Periodic timer reloads from the preset on underflow; preset 0001h to FFFFh.
// - Writing one to the restart bit restarts the timer on the next input-clock edge.
// - Hardware clears the restart bit on the very edge that restarts the timer.
// - Read-only terminal-count flag sets when the timer reaches zero; writes ignored.
// - With interrupt enable set, each count to zero raises a CPU interrupt.
// - Last-touch-delay bit shows a watchdog data write still in progress.
// - With freeze enable set, the debug freeze input stops the timer.
// - Control and status register clears its non-reserved bits at reset.
// - First count-register write starts the watchdog; later writes reload it; reset 0Fh.
// - Keyed servicing: writing 5Ch reloads the watchdog from the count register.
// - Keyed servicing: writing any other key value is a watchdog error.
// - Two key writes within one watchdog clock cycle are a watchdog error.
// - Keyed servicing disabled: key register writes are ignored.
// - Timer input clock is one of six rates, slow clock divided by 1 to 32.
// - Count value is the most watchdog cycles between services; later is an error.
// - Any watchdog error requests a reset of the whole device.
// - A configuration bit clocks the watchdog by timer input clock or underflow.
// - Locked registers ignore writes and read unreliably; lock bits stick until reset.
// - Divider codes 000 to 101 divide the slow clock by 1 to 32; others reserved.
package twu_pkg;

  // ******************************************************************
  // Register map (word index on the register port)
  // ******************************************************************
  localparam logic [2:0] OFS_CFG    = 3'h0;
  localparam logic [2:0] OFS_PRESC  = 3'h1;
  localparam logic [2:0] OFS_RELOAD = 3'h2;
  localparam logic [2:0] OFS_CSR    = 3'h3;
  localparam logic [2:0] OFS_WD_COUNT = 3'h4;
  localparam logic [2:0] OFS_KEY    = 3'h5;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int CFG_LOCK_CFG   = 0;
  localparam int CFG_LOCK_PRESC = 1;
  localparam int CFG_LOCK_TMR   = 2;
  localparam int CFG_LOCK_WD_COUNT = 3;
  localparam int CFG_WD_CLK_SEL = 4;
  localparam int CFG_KEYED      = 5;
  localparam int CSR_RESTART    = 0;
  localparam int CSR_TERM       = 1;
  localparam int CSR_IRQ_EN     = 2;
  localparam int CSR_LTD        = 3;
  localparam int CSR_FREEZE_EN  = 4;

  // ******************************************************************
  // Reset values and codes
  // ******************************************************************
  localparam logic [5:0]  CFG_RST    = 6'h00;
  localparam logic [2:0]  PRESC_RST  = 3'h0;
  localparam logic [15:0] RELOAD_RST = 16'hffff;
  localparam logic [7:0]  WD_COUNT_RST = 8'h0f;
  localparam logic [7:0]  SERVICE_KEY = 8'h5c;
  localparam logic [2:0]  DIV_CODE_MAX = 3'h5;

  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

endpackage : twu_pkg

// *** verification/timer_watchdog_unit_tb.sv ***
// Self-checking testbench for the timer and watchdog unit
`timescale 1ns/1ps
module timer_watchdog_unit_tb;
  import twu_pkg::*;

  // ******************************************************************
  // Signals
  // ******************************************************************
  logic        mclk      = 1'b0;
  logic        reset     = 1'b1;
  logic        clk_en    = 1'b1;
  logic        slow_clk  = 1'b0;
  logic        freeze_in = 1'b0;
  reg_req_type req       = '0;
  logic [15:0] rdata;
  logic        timer_irq;
  logic        wd_reset;
  logic [3:0]  sc_cnt    = 4'h0;
  logic [15:0] rv;
  int          failures  = 0;
  int          n_checks  = 0;
  int          t;
  logic [15:0] rst_exp [8] = '{16'h0000, 16'h0000, 16'hffff, 16'h0000,
                               16'h0000, 16'h0000, 16'h0000, 16'h0000};

  timer_watchdog_unit u_timer_watchdog_unit (
    .mclk      (mclk),
    .reset     (reset),
    .clk_en    (clk_en),
    .slow_clk  (slow_clk),
    .freeze_in (freeze_in),
    .bus_req   (req),
    .rdata     (rdata),
    .timer_irq (timer_irq),
    .wd_reset  (wd_reset)
  );

  always #2 mclk = ~mclk;

  // Slow clock at 1/16 of mclk keeps the synchroniser well inside its ratio
  always @(posedge mclk)
  begin
    sc_cnt   <= sc_cnt + 4'h1;
    slow_clk <= sc_cnt[3];
  end

  // ******************************************************************
  // Tasks
  // ******************************************************************
  task automatic end_sim;
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  // Returns 3000 when no pulse comes; a gap is measured pulse to pulse
  task automatic wait_irq(output int c);
    c = 0;
    do
    begin
      @(posedge mclk);
      #1;
      c++;
    end
    while (timer_irq !== 1'b1 && c < 3000);
  endtask : wait_irq

  task automatic do_reset;
    @(posedge mclk);
    reset <= 1'b1;
    req   <= '0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
  endtask : do_reset

  // Align to just after a watchdog tick so a window of one tick is known
  task automatic after_tick;
    @(posedge slow_clk);
    idle(6);
  endtask : after_tick

  initial
  begin
    #200000;
    failures++;
    end_sim();
  end

  // ******************************************************************
  // Tests
  // ******************************************************************
  initial
  begin
    do_reset();
    for (int i = 0; i < 8; i++)
    begin
      rd(3'(i), rv);
      chk_word("reset_read", rst_exp[i], rv);
    end
    wr(OFS_RELOAD, 16'h0003);
    wr(OFS_CSR, 16'h0005);
    wait_irq(t);
    chk_bit("restart_irq", 1'b1, t < 200);
    wait_irq(t);
    chk_word("period_reload3", 16'h0040, 16'(t));
    rd(OFS_CSR, rv);
    chk_word("csr_after_underflow", 16'h0006, rv);
    wr(OFS_CSR, 16'h0006);
    rd(OFS_CSR, rv);
    chk_word("csr_tc_write", 16'h0004, rv);
    wr(OFS_RELOAD, 16'h0001);
    wait_irq(t);
    wait_irq(t);
    chk_word("period_reload1", 16'h0020, 16'(t));
    for (int c = 1; c < 6; c++)
    begin
      wr(OFS_PRESC, 16'(c));
      wait_irq(t);
      wait_irq(t);
      chk_word("period_divider", 16'h0020 << c, 16'(t));
    end
    wr(OFS_PRESC, 16'h0006);
    wait_irq(t);
    wait_irq(t);
    chk_word("reserved_divider", 16'd3000, 16'(t));
    wr(OFS_PRESC, 16'h0000);
    wr(OFS_CSR, 16'h0014);
    wait_irq(t);
    @(posedge mclk);
    freeze_in <= 1'b1;
    wait_irq(t);
    chk_word("frozen", 16'd3000, 16'(t));
    wr(OFS_CSR, 16'h0004);
    wait_irq(t);
    chk_bit("freeze_ignored", 1'b1, t < 200);
    @(posedge mclk);
    freeze_in <= 1'b0;
    wr(OFS_CSR, 16'h0000);
    wait_irq(t);
    wait_irq(t);
    chk_word("irq_disabled", 16'd3000, 16'(t));

    // No error on the underflow watchdog clock choice, late service on the input-clock choice
    do_reset();
    wr(OFS_WD_COUNT, 16'h0001);
    idle(300);
    chk_bit("wd_on_underflow", 1'b0, wd_reset);
    after_tick();
    wr(OFS_CFG, 16'h0010);
    wr(OFS_WD_COUNT, 16'h0002);
    rd(OFS_CSR, rv);
    chk_word("last_touch_set", 16'h0008, rv & 16'h0008);
    idle(20);
    chk_bit("wd_in_time", 1'b0, wd_reset);
    rd(OFS_CSR, rv);
    chk_word("last_touch_clear", 16'h0000, rv & 16'h0008);
    idle(60);
    chk_bit("wd_late", 1'b1, wd_reset);

    // Servicing by count writes and by key
    do_reset();
    wr(OFS_CFG, 16'h0010);
    wr(OFS_KEY, 16'h0033);
    idle(100);
    chk_bit("key_ignored", 1'b0, wd_reset);
    repeat (8)
    begin
      wr(OFS_WD_COUNT, 16'h0002);
      idle(20);
    end
    chk_bit("count_service", 1'b0, wd_reset);
    wr(OFS_CFG, 16'h0030);
    repeat (8)
    begin
      wr(OFS_KEY, 16'h005c);
      idle(20);
    end
    chk_bit("key_service", 1'b0, wd_reset);
    wr(OFS_KEY, 16'h005d);
    idle(3);
    chk_bit("wrong_key", 1'b1, wd_reset);

    do_reset();
    wr(OFS_CFG, 16'h0030);
    wr(OFS_WD_COUNT, 16'h0008);
    after_tick();
    wr(OFS_KEY, 16'h005c);
    wr(OFS_KEY, 16'h005c);
    idle(3);
    chk_bit("key_too_often", 1'b1, wd_reset);

    // Full protected setup, then locking
    do_reset();
    wr(OFS_PRESC, 16'h0000);
    wr(OFS_RELOAD, 16'h0003);
    wr(OFS_CFG, 16'h0010);
    wr(OFS_WD_COUNT, 16'h0008);
    wr(OFS_CSR, 16'h0001);
    wr(OFS_CFG, 16'h003f);
    rd(OFS_CFG, rv);
    chk_word("locked_cfg_read", 16'h0000, rv);
    rd(OFS_RELOAD, rv);
    chk_word("locked_reload_read", 16'h0000, rv);
    wr(OFS_CFG, 16'h0000);
    after_tick();
    wr(OFS_KEY, 16'h0000);
    idle(3);
    chk_bit("lock_sticks", 1'b1, wd_reset);
    end_sim();
  end

endmodule : timer_watchdog_unit_tb
